// file: hw/slc_consts.svh
// constants of the segment display controller: addresses, fields, codes and dividers
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH

// data space addresses
`define SLC_CTRL_ADDR 8'hdc
`define SLC_RAM_BASE 8'he0
`define SLC_RAM_LAST 8'hf7
`define SLC_RAM_BYTES 24
`define SLC_BYTES_PER_COM 6
`define SLC_NUM_SEG 45

// mode control fields
`define SLC_MUX_HI 7
`define SLC_MUX_LO 6
`define SLC_SRC_HI 5
`define SLC_SRC_LO 3
`define SLC_BASE_HI 2
`define SLC_BASE_LO 0
`define SLC_CTRL_RESET 8'h00

// multiplexing ratio codes
`define SLC_MUX_FOUR 2'h0
`define SLC_MUX_ONE 2'h1
`define SLC_MUX_TWO 2'h2
`define SLC_MUX_THREE 2'h3

// clock source codes
`define SLC_SRC_OFF 3'h0
`define SLC_SRC_AUX 3'h1
`define SLC_SRC_RSV_A 3'h2
`define SLC_SRC_DIV32 3'h3
`define SLC_SRC_DIV64 3'h4
`define SLC_SRC_DIV128 3'h5
`define SLC_SRC_DIV256 3'h6
`define SLC_SRC_RSV_B 3'h7

// main clock division factors
`define SLC_MAIN_DIV32 9'h020
`define SLC_MAIN_DIV64 9'h040
`define SLC_MAIN_DIV128 9'h080
`define SLC_MAIN_DIV256 9'h100

// base frequency division factors of the 32 kHz clock
`define SLC_BASE_RSV 3'h7
`define SLC_BASE_DIV0 10'h200
`define SLC_BASE_DIV1 10'h182
`define SLC_BASE_DIV2 10'h100
`define SLC_BASE_DIV3 10'h0c0
`define SLC_BASE_DIV4 10'h080
`define SLC_BASE_DIV5 10'h060
`define SLC_BASE_DIV6 10'h040

`endif

// file: hw/slc_divider.sv
// pulse divider: one tick out for every limit steps in
`timescale 1ns/1ns
module slc_divider #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // control
  input wire logic CLR,
  input wire logic STEP,
  input wire logic [W-1:0] LIMIT,
  // result
  output logic TICK
);
  import slc_pkg::*;

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cnt = cnt;
    TICK = STEP && (cnt == W'(LIMIT - W'(1)));
    if (CLR) begin
      next_cnt = '0;
      TICK = 1'b0;
    end else if (TICK) begin
      next_cnt = '0;
    end else if (STEP) begin
      next_cnt = W'(cnt + W'(1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cnt <= '0;
    end else if (CE) begin
      cnt <= next_cnt;
    end
  end

endmodule // slc_divider

// file: hw/slc_pkg.sv
// types of the segment display controller
package slc_pkg;

  // mode control register layout
  typedef struct packed {
    logic [1:0] mux;
    logic [2:0] src;
    logic [2:0] base;
  } slc_cfg_t;

  // panel drive levels
  typedef struct packed {
    logic en;
    logic [3:0] com;
    logic [44:0] seg;
  } slc_drive_t;

  // data space access
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } slc_bus_t;

  typedef enum logic [1:0] {
    SLC_OFF = 2'b00,
    SLC_RUN = 2'b01
  } slc_fsm_t;

  typedef struct packed {
    slc_fsm_t fsm;
    slc_cfg_t ctrl;
    slc_cfg_t act;
    logic [1:0] com_idx;
    logic [7:0] rdata;
    slc_drive_t drv;
    logic frame_end;
  } slc_regs_t;

  typedef struct packed {
    logic [9:0] cnt;
  } slc_div_regs_t;

endpackage

// file: hw/slc_top.sv
// multiplexed segment display controller with display memory and mode control
//
// Summary of operation
// - each memory bit lights one segment/common element when set, dark when clear.
// - display memory is never cleared by reset.
// - memory of unused commons stays ordinary read/write storage.
// - display memory spans E0 to F7, six bytes per common.
// - first byte bits 7-3 hold segments 4-8; later bytes eight segments each.
// - stop while running from the main clock switches the controller off.
// - when switched off, all segment and common outputs go to ground.
// - with the auxiliary 32 kHz source the display keeps running in stop.
// - a source or function change takes effect at frame end while running; when switched off it is taken at once unless in stop.
// - source 0 is off, 1 auxiliary, 2 and 7 reserved, others divide.
// - mode control register sits at DC and is read/write.
// - mode bits 5-3 select clock source and main divider.
// - mode bits 2-0 select the base frame frequency.
// - base dividers 512, 386, 256, 192, 128, 96, 64; code 7 reserved.
// - mux code 00 four commons, 01 one, 10 two, 11 three.
// - main dividers 32, 64, 128, 256 for source codes 3 to 6.
// - frame rate is base rate over the number of active commons.
// - a failed controller clock grounds all segment and common outputs.
`timescale 1ns/1ns
`include "slc_consts.svh"
module slc_top (
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // data space access
  input wire slc_pkg::slc_bus_t BUS,
  output logic [7:0] RDATA,
  // system state
  input wire logic STOP,
  input wire logic AUX_TICK,
  input wire logic CLK_FAIL,
  // panel drive
  output logic DRIVE_EN,
  output logic [3:0] COM,
  output logic [44:0] SEG,
  // status
  output logic FRAME_END,
  output logic RUNNING
);
  import slc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and memory

  slc_regs_t r;
  slc_regs_t next_r;
  logic [7:0] ram [0:`SLC_RAM_BYTES-1];

  logic ram_hit;
  logic ctrl_hit;
  logic [4:0] ram_idx;
  logic [8:0] main_div;
  logic [9:0] base_div;
  logic src_main;
  logic src_ok;
  logic base_ok;
  logic stop_kill;
  logic halt;
  logic [1:0] last_com;
  logic pre_step;
  logic pre_tick;
  logic tick32;
  logic slot_tick;
  logic div_clr;
  logic [4:0] seg_base;
  logic [44:0] seg_now;
  logic [3:0] com_now;
  logic [7:0] rd_value;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  always_comb begin
    ctrl_hit = (BUS.addr == `SLC_CTRL_ADDR);
    ram_hit = (BUS.addr >= `SLC_RAM_BASE) && (BUS.addr <= `SLC_RAM_LAST);
    ram_idx = 5'(BUS.addr - `SLC_RAM_BASE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of the active configuration

  always_comb begin
    src_main = 1'b1;
    main_div = `SLC_MAIN_DIV32;
    case (r.act.src)
      `SLC_SRC_DIV32: begin
        main_div = `SLC_MAIN_DIV32;
      end
      `SLC_SRC_DIV64: begin
        main_div = `SLC_MAIN_DIV64;
      end
      `SLC_SRC_DIV128: begin
        main_div = `SLC_MAIN_DIV128;
      end
      `SLC_SRC_DIV256: begin
        main_div = `SLC_MAIN_DIV256;
      end
      default: begin
        src_main = 1'b0;
      end
    endcase
    src_ok = src_main || (r.act.src == `SLC_SRC_AUX);
  end

  always_comb begin
    base_ok = (r.act.base != `SLC_BASE_RSV);
    case (r.act.base)
      3'h0: begin
        base_div = `SLC_BASE_DIV0;
      end
      3'h1: begin
        base_div = `SLC_BASE_DIV1;
      end
      3'h2: begin
        base_div = `SLC_BASE_DIV2;
      end
      3'h3: begin
        base_div = `SLC_BASE_DIV3;
      end
      3'h4: begin
        base_div = `SLC_BASE_DIV4;
      end
      3'h5: begin
        base_div = `SLC_BASE_DIV5;
      end
      3'h6: begin
        base_div = `SLC_BASE_DIV6;
      end
      default: begin
        base_div = `SLC_BASE_DIV0;
      end
    endcase
  end

  always_comb begin
    case (r.act.mux)
      `SLC_MUX_ONE: begin
        last_com = 2'h0;
      end
      `SLC_MUX_TWO: begin
        last_com = 2'h1;
      end
      `SLC_MUX_THREE: begin
        last_com = 2'h2;
      end
      default: begin
        last_com = 2'h3;
      end
    endcase
  end

  // the main clock is gone in stop; only the auxiliary source survives it
  always_comb begin
    stop_kill = STOP && (r.act.src != `SLC_SRC_AUX);
    halt = stop_kill || CLK_FAIL || !src_ok || !base_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock chain: 32 kHz tick, then one base period per common slot

  always_comb begin
    div_clr = (r.fsm != SLC_RUN);
    pre_step = src_main && !div_clr;
    tick32 = (r.act.src == `SLC_SRC_AUX) ? AUX_TICK : pre_tick;
  end

  slc_divider #(
    .W(9)
  ) u_prescale (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .CE(CE),
    .CLR(div_clr),
    .STEP(pre_step),
    .LIMIT(main_div),
    .TICK(pre_tick)
  );

  slc_divider #(
    .W(10)
  ) u_base (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .CE(CE),
    .CLR(div_clr),
    .STEP(tick32),
    .LIMIT(base_div),
    .TICK(slot_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // segment pattern of the current common

  always_comb begin
    seg_base = 5'(r.com_idx * 3'(`SLC_BYTES_PER_COM));
    // seg[0] is segment 4; low three bits of the first byte are not wired
    seg_now = {ram[5'(seg_base + 5'h05)], ram[5'(seg_base + 5'h04)],
               ram[5'(seg_base + 5'h03)], ram[5'(seg_base + 5'h02)],
               ram[5'(seg_base + 5'h01)], ram[seg_base][7:3]};
    com_now = 4'(4'h1 << r.com_idx);
  end

  always_comb begin
    rd_value = 8'h00;
    if (ctrl_hit) begin
      rd_value = r.ctrl;
    end else if (ram_hit) begin
      rd_value = ram[ram_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    next_r.frame_end = 1'b0;
    if (BUS.wr && ctrl_hit) begin
      next_r.ctrl = slc_cfg_t'(BUS.wdata);
    end
    if (BUS.rd) begin
      next_r.rdata = rd_value;
    end
    case (r.fsm)
      SLC_OFF: begin
        next_r.com_idx = 2'h0;
        next_r.drv = '0;
        // an idle controller out of stop takes the setting at once; it has no frame to finish
        if (!STOP) begin
          next_r.act = r.ctrl;
          if (!halt) begin
            next_r.fsm = SLC_RUN;
          end
        end
      end
      SLC_RUN: begin
        if (halt) begin
          next_r.fsm = SLC_OFF;
          next_r.drv = '0;
          next_r.com_idx = 2'h0;
        end else begin
          if (slot_tick) begin
            if (r.com_idx == last_com) begin
              next_r.com_idx = 2'h0;
              next_r.frame_end = 1'b1;
              next_r.act = r.ctrl;
            end else begin
              next_r.com_idx = 2'(r.com_idx + 2'h1);
            end
          end
          next_r.drv.en = 1'b1;
          next_r.drv.com = com_now;
          next_r.drv.seg = seg_now;
        end
      end
      default: begin
        next_r.fsm = SLC_OFF;
        next_r.drv = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      r.fsm <= SLC_OFF;
      r.ctrl <= slc_cfg_t'(`SLC_CTRL_RESET);
      r.act <= slc_cfg_t'(`SLC_CTRL_RESET);
      r.com_idx <= 2'h0;
      r.rdata <= 8'h00;
      r.drv <= '0;
      r.frame_end <= 1'b0;
    end else if (CE) begin
      r <= next_r;
    end
  end

  // no reset on the display memory
  always_ff @(posedge REF_CLK) begin
    if (CE && BUS.wr && ram_hit) begin
      ram[ram_idx] <= BUS.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    RDATA = r.rdata;
    DRIVE_EN = r.drv.en;
    COM = r.drv.com;
    SEG = r.drv.seg;
    FRAME_END = r.frame_end;
    RUNNING = (r.fsm == SLC_RUN);
  end

endmodule // slc_top

// file: tb/segment_lcd_controller_tb.sv
// self-checking bench of the segment display controller
`timescale 1ns/1ns
`include "slc_consts.svh"
module segment_lcd_controller_tb;
  import slc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, stop = 1'b0, aux_tick = 1'b0, clk_fail = 1'b0;
  slc_bus_t bus = '0;
  logic [7:0] rdata;
  logic drive_en, frame_end, running, dc_bias;
  logic [3:0] com;
  logic [44:0] seg;
  logic [3:0][44:0] image;
  int mismatches = 0, n_compared = 0, ticks = 0, cyc = 0, last_ticks = 0, last_cyc = 0;
  int mem [24];
  int mode = 0, prev = 192;
  int divs [7] = '{512, 386, 256, 192, 128, 96, 64};
  logic [7:0] resv [4] = '{8'h56, 8'h7e, 8'h4f, 8'h46};
  always #10 ref_clk = ~ref_clk;
  always @(negedge ref_clk) aux_tick <= ~aux_tick;
  slc_top DUT (.REF_CLK(ref_clk), .RST(rst), .CE(1'b1), .BUS(bus), .RDATA(rdata), .STOP(stop),
    .AUX_TICK(aux_tick), .CLK_FAIL(clk_fail), .DRIVE_EN(drive_en), .COM(com), .SEG(seg),
    .FRAME_END(frame_end), .RUNNING(running));
  slc_panel u_panel (.REF_CLK(ref_clk), .DRIVE_EN(drive_en), .COM(com), .SEG(seg),
    .IMAGE(image), .DC_BIAS(dc_bias));
  // frame length in ticks and in cycles
  always @(posedge ref_clk) begin
    if (aux_tick && running) ticks++;
    cyc++;
    if (frame_end) begin
      last_ticks = ticks;
      last_cyc = cyc;
      ticks = 0;
      cyc = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [44:0] exp, logic [44:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkn(string what, int exp, int got);
    n_compared++;
    if (got != exp) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk);
    bus = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge ref_clk);
    bus.wr = 1'b0;
    if (a == `SLC_CTRL_ADDR) mode = d;
    else if (a >= `SLC_RAM_BASE && a <= 8'hf7) mem[a - `SLC_RAM_BASE] = d;
  endtask
  task automatic rd(logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == `SLC_CTRL_ADDR) e = mode[7:0];
    else if (a >= `SLC_RAM_BASE && a <= 8'hf7) e = mem[a - `SLC_RAM_BASE][7:0];
    @(negedge ref_clk);
    bus = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge ref_clk);
    bus.rd = 1'b0;
    chk("read data", 45'(e), 45'(rdata));
  endtask
  task automatic frames(int n);
    int k;
    k = 0;
    while (n > 0 && k < 40000) begin
      @(negedge ref_clk);
      k++;
      if (frame_end === 1'b1) n--;
    end
    // one more edge so the frame counters hold the frame just ended
    @(negedge ref_clk);
    chkn("frames left", 0, n);
  endtask
  task automatic until_run(logic v);
    int k;
    for (k = 0; k < 3000 && running !== v; k++) @(negedge ref_clk);
    chk("running", 45'(v), 45'(running));
  endtask
  // expected segment row of one common from the memory model
  function automatic logic [44:0] row(int c);
    logic [44:0] r;
    for (int b = 0; b < 45; b++) r[b] = mem[6 * c + (b + 3) / 8][(b + 3) % 8];
    return r;
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // the tests need about 60000 cycles; the longest are the slow main-source frames
  initial begin
    repeat (80000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(2213));
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    rd(`SLC_CTRL_ADDR);
    chk("drive enable", 45'h0, 45'(drive_en));
    $display("test reset done");
    wr(`SLC_CTRL_ADDR, 8'h4e);
    until_run(1'b1);
    for (int i = 0; i < 24; i++) wr(8'he0 + 8'(i), 8'($urandom));
    for (int i = 0; i < 24; i++) rd(8'he0 + 8'(i));
    wr(8'hf8, 8'h5a);
    rd(8'hf8);
    rd(8'hdb);
    $display("test memory done");
    // mid-run reset clears the mode register but keeps the display memory
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    mode = 0;
    until_run(1'b0);
    for (int i = 0; i < 24; i += 5) rd(8'he0 + 8'(i));
    rd(`SLC_CTRL_ADDR);
    wr(`SLC_CTRL_ADDR, 8'h4e);
    until_run(1'b1);
    $display("test mid reset done");
    for (int m = 0; m < 4; m++) begin
      int n;
      n = m == 0 ? 4 : m;
      wr(`SLC_CTRL_ADDR, {2'(m), 6'h0e});
      frames(2);
      chkn("ticks per frame", 64 * n, last_ticks);
      for (int c = 0; c < n; c++) chk("panel row", row(c), image[c]);
    end
    $display("test mux done");
    for (int b = 0; b < 7; b++) begin
      wr(`SLC_CTRL_ADDR, {5'h09, 3'(b)});
      frames(1);
      chkn("old frame", prev, last_ticks);
      frames(2);
      chkn("ticks per frame", divs[b], last_ticks);
      prev = divs[b];
    end
    $display("test base done");
    foreach (resv[i]) begin
      wr(`SLC_CTRL_ADDR, resv[i]);
      until_run(1'b0);
      @(negedge ref_clk);
      chk("drive enable", 45'h0, 45'(drive_en));
      wr(`SLC_CTRL_ADDR, 8'h4e);
      until_run(1'b1);
    end
    $display("test reserved done");
    frames(2);
    stop = 1'b1;
    frames(2);
    chkn("ticks in stop", 64, last_ticks);
    stop = 1'b0;
    $display("test aux stop done");
    for (int s = 3; s < 7; s++) begin
      wr(`SLC_CTRL_ADDR, {2'h1, 3'(s), 3'h6});
      frames(2);
      chkn("cycles per frame", 64 * (32 << (s - 3)), last_cyc);
    end
    $display("test main source done");
    stop = 1'b1;
    until_run(1'b0);
    repeat (2) @(negedge ref_clk);
    chk("common lines", 45'h0, 45'(com));
    wr(`SLC_CTRL_ADDR, 8'h4e);
    repeat (20) @(negedge ref_clk);
    chk("running in stop", 45'h0, 45'(running));
    stop = 1'b0;
    until_run(1'b1);
    $display("test main stop done");
    clk_fail = 1'b1;
    until_run(1'b0);
    clk_fail = 1'b0;
    chk("panel bias", 45'h0, 45'(dc_bias));
    $display("test clock fail done");
    tally_and_finish();
  end
endmodule // segment_lcd_controller_tb

// file: tb/slc_panel.sv
// glass panel model: keeps the lit pattern of every backplane
`timescale 1ns/1ns
module slc_panel (
  // clock
  input wire logic REF_CLK,
  // electrodes
  input wire logic DRIVE_EN,
  input wire logic [3:0] COM,
  input wire logic [44:0] SEG,
  // observed image
  output logic [3:0][44:0] IMAGE,
  output logic DC_BIAS
);
  logic bias_seen = 1'b0;
  assign DC_BIAS = bias_seen;
  always @(posedge REF_CLK) begin
    for (int c = 0; c < 4; c++) begin
      if (DRIVE_EN && COM == 4'h1 << c) IMAGE[c] <= SEG;
    end
    if (!DRIVE_EN && (COM != 4'h0 || SEG != 45'h0)) bias_seen <= 1'b1;
  end
endmodule // slc_panel

// file: tb/slc_properties.sv
// port assertions of the segment display controller
`timescale 1ns/1ns
`include "slc_consts.svh"
module slc_chk (
  // clock
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // bus
  input wire slc_pkg::slc_bus_t BUS,
  input wire logic [7:0] RDATA,
  // system
  input wire logic STOP,
  input wire logic AUX_TICK,
  input wire logic CLK_FAIL,
  // panel
  input wire logic DRIVE_EN,
  input wire logic [3:0] COM,
  input wire logic [44:0] SEG,
  input wire logic FRAME_END,
  input wire logic RUNNING
);
  import slc_pkg::*;
  logic [7:0] mode;
  logic mapped;
  assign mapped = BUS.addr == `SLC_CTRL_ADDR || (BUS.addr >= `SLC_RAM_BASE && BUS.addr <= 8'hf7);
  // shadow of the last written mode byte
  always_ff @(posedge REF_CLK) begin
    if (RST) mode <= `SLC_CTRL_RESET;
    else if (CE && BUS.wr && BUS.addr == `SLC_CTRL_ADDR) mode <= BUS.wdata;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_rd_mode;
    CE && BUS.rd && BUS.addr == `SLC_CTRL_ADDR;
  endsequence
  sequence s_rd_hole;
    CE && BUS.rd && !mapped;
  endsequence
  AST_RESET_STATE: assert property ($fell(RST) |-> !RUNNING && !DRIVE_EN && RDATA == 8'h00)
    else $error("state not cleared by reset");
  AST_MODE_READ: assert property (s_rd_mode |=> RDATA == $past(mode))
    else $error("mode readback differs");
  AST_HOLE_READ: assert property (s_rd_hole |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_OFF_GROUND: assert property (!DRIVE_EN |-> COM == 4'h0 && SEG == 45'h0)
    else $error("lines driven while off");
  AST_ONE_COM: assert property (DRIVE_EN |-> $onehot(COM))
    else $error("not one common active");
  AST_FRAME_PULSE: assert property (FRAME_END |=> !FRAME_END)
    else $error("frame end longer than a cycle");
  AST_FAIL_OFF: assert property (CE && CLK_FAIL |-> ##[1:2] !DRIVE_EN)
    else $error("clock failure left drive on");
  AST_STOP_HOLD: assert property (CE && STOP && !RUNNING |=> !RUNNING)
    else $error("restart during stop");
  AST_RUN_DRIVE: assert property (CE && $rose(RUNNING) |=> DRIVE_EN)
    else $error("drive late after start");
endmodule // slc_chk
////////////////////////////////////////////////////////////////////////////////
bind slc_top slc_chk u_chk (.REF_CLK(REF_CLK), .RST(RST), .CE(CE), .BUS(BUS), .RDATA(RDATA),
  .STOP(STOP), .AUX_TICK(AUX_TICK), .CLK_FAIL(CLK_FAIL), .DRIVE_EN(DRIVE_EN), .COM(COM),
  .SEG(SEG), .FRAME_END(FRAME_END), .RUNNING(RUNNING));
